// [hdl/pin_change_interrupt.sv]
// Purpose: Pin-change interrupt logic with per-pin edge enables, sticky flags and wake
// Assumes: Pin inputs synchronous to clk_sys_in; Avalon-MM slave with waitrequest
// Notes:   Every access takes two cycles: one wait cycle, then one ack cycle
`timescale 1ns/10ps
`include "pin_change_interrupt_regs.svh"

// How it works
// - Per pin, threshold bit one takes the Schmitt input and zero the TTL input, for reads and edges.
// - Bits 7-6 of threshold, rising-enable, falling-enable and flag registers read as zero.
// - The interrupt line is high only while the master enable is set and some pin flag is set.
// - With the master enable clear, edges still set pin flags but raise no interrupt.
// - A rising-enable bit of one arms the pin's positive-edge detector, zero disables it.
// - A falling-enable bit of one arms the pin's negative-edge detector, zero disables it.
// - With both enables set, a pin reacts to edges of either polarity.
// - An enabled rising or falling edge sets the pin flag, which stays set until software clears it.
// - The summary flag in the core control register is the OR of all pin flags.
// - Software clears a pin flag by writing zero to it.
// - An enabled edge in the cycle of a flag write leaves that flag set whatever was written.
// - With the master enable set, an enabled edge wakes the device from sleep.
// - An edge seen in sleep sets its flag no later than the wake pulse.
module pin_change_interrupt #(
  parameter int NUM_PINS = 6
) (
  input  wire logic                   clk_sys_in,
  input  wire logic                   reset_n_in,
  input  wire logic [NUM_PINS-1:0]    pin_schmitt_in,
  input  wire logic [NUM_PINS-1:0]    pin_ttl_in,
  input  wire logic                   sleep_in,
  input  wire logic [`PCI_ADDR_W-1:0] avs_address_in,
  input  wire logic                   avs_read_in,
  input  wire logic                   avs_write_in,
  input  wire logic [31:0]            avs_writedata_in,
  input  wire logic [3:0]             avs_byteenable_in,
  output logic [31:0]                 avs_readdata_out,
  output logic                        avs_waitrequest_out,
  output logic                        irq_out,
  output logic                        wake_out,
  output logic [NUM_PINS-1:0]         pin_level_out
);

  if (NUM_PINS < 1 || NUM_PINS > 6) begin : g_bad_pins
    $error("NUM_PINS must lie between 1 and 6");
  end

  localparam int PAD = 32 - NUM_PINS;

  // Register state
  logic [NUM_PINS-1:0] threshold_sel;
  logic [NUM_PINS-1:0] rise_en;
  logic [NUM_PINS-1:0] fall_en;
  logic [NUM_PINS-1:0] flags;
  logic [NUM_PINS-1:0] evt_status;
  logic [NUM_PINS-1:0] evt_mask;
  logic                master_en;

  // Input path
  logic [NUM_PINS-1:0] pin_meta;
  logic [NUM_PINS-1:0] pin_sync;
  logic [NUM_PINS-1:0] pin_prev;
  logic [NUM_PINS-1:0] pin_chosen;
  logic [NUM_PINS-1:0] rise_pulse;
  logic [NUM_PINS-1:0] fall_pulse;
  logic [NUM_PINS-1:0] edge_hit;

  // Bus path
  pin_change_interrupt_pkg::bus_phase_t bus_phase;
  pin_change_interrupt_pkg::bus_phase_t next_bus_phase;
  logic                bus_req;
  logic                bus_done;
  logic                wr_done;
  logic                rd_done;
  logic                wr_low;
  logic                sel_thresh;
  logic                sel_ctrl;
  logic                sel_rise;
  logic                sel_fall;
  logic                sel_flags;
  logic                sel_status;
  logic                sel_mask;
  logic                sel_level;
  logic [NUM_PINS-1:0] wr_pins;
  logic [31:0]         rd_value;
  logic                summary;
  logic                status_rd_clear;
  logic [NUM_PINS-1:0] next_flags;
  logic [NUM_PINS-1:0] next_evt_status;
  logic                next_irq;
  logic                next_wake;

  // Threshold choice per pin
  genvar gi;
  for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
    assign pin_chosen[gi] = threshold_sel[gi] ? pin_schmitt_in[gi] : pin_ttl_in[gi];
  end

  // Two-stage synchroniser, then one stage of history
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= pin_chosen;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign rise_pulse = pin_sync & ~pin_prev;
  assign fall_pulse = ~pin_sync & pin_prev;
  assign edge_hit   = (rise_pulse & rise_en)
                    | (fall_pulse & fall_en);

  // Bus decode
  assign bus_req    = avs_read_in | avs_write_in;
  assign bus_done   = bus_req && (bus_phase == pin_change_interrupt_pkg::BUS_ACK);
  assign wr_done    = bus_done && avs_write_in;
  assign rd_done    = bus_done && avs_read_in;
  assign wr_low     = wr_done && avs_byteenable_in[0];
  assign wr_pins    = avs_writedata_in[NUM_PINS-1:0];
  assign sel_thresh = (avs_address_in == `PCI_OFS_THRESHOLD);
  assign sel_ctrl   = (avs_address_in == `PCI_OFS_CORE_CTRL);
  assign sel_rise   = (avs_address_in == `PCI_OFS_RISE_EN);
  assign sel_fall   = (avs_address_in == `PCI_OFS_FALL_EN);
  assign sel_flags  = (avs_address_in == `PCI_OFS_FLAGS);
  assign sel_status = (avs_address_in == `PCI_OFS_EVT_STATUS);
  assign sel_mask   = (avs_address_in == `PCI_OFS_EVT_MASK);
  assign sel_level  = (avs_address_in == `PCI_OFS_PIN_LEVEL);

  assign summary = |flags;

  // Upper bits pad with zero
  assign rd_value = sel_thresh ? {{PAD{1'b0}}, threshold_sel} :
                    sel_ctrl   ? {28'h000_0000, master_en, 2'b00, summary} :
                    sel_rise   ? {{PAD{1'b0}}, rise_en} :
                    sel_fall   ? {{PAD{1'b0}}, fall_en} :
                    sel_flags  ? {{PAD{1'b0}}, flags} :
                    sel_status ? {{PAD{1'b0}}, evt_status} :
                    sel_mask   ? {{PAD{1'b0}}, evt_mask} :
                    sel_level  ? {{PAD{1'b0}}, pin_sync} :
                    `PCI_READ_UNMAPPED;

  // Hardware set wins over any write in the same cycle
  assign next_flags = (wr_low && sel_flags) ? (wr_pins | edge_hit)
                                            : (flags | edge_hit);
  assign status_rd_clear = rd_done && sel_status;
  assign next_evt_status = status_rd_clear ? edge_hit : (evt_status | edge_hit);

  // Interrupt needs the master enable and a live pin flag
  assign next_irq  = master_en && |(next_flags & evt_mask);
  assign next_wake = sleep_in && master_en && |edge_hit;

  assign next_bus_phase = (bus_req && bus_phase == pin_change_interrupt_pkg::BUS_WAIT)
                        ? pin_change_interrupt_pkg::BUS_ACK
                        : pin_change_interrupt_pkg::BUS_WAIT;

  // Bus handshake: one wait cycle, data loaded with the ack
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bus_phase           <= pin_change_interrupt_pkg::BUS_WAIT;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
    end else begin
      bus_phase           <= next_bus_phase;
      avs_waitrequest_out <= (next_bus_phase != pin_change_interrupt_pkg::BUS_ACK);
      if (avs_read_in && next_bus_phase == pin_change_interrupt_pkg::BUS_ACK) begin
        avs_readdata_out <= rd_value;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      threshold_sel <= NUM_PINS'(`PCI_RST_THRESHOLD);
      rise_en       <= NUM_PINS'(`PCI_RST_RISE_EN);
      fall_en       <= NUM_PINS'(`PCI_RST_FALL_EN);
      evt_mask      <= NUM_PINS'(`PCI_RST_EVT_MASK);
      master_en     <= `PCI_RST_MASTER_EN;
    end else if (wr_low) begin
      if (sel_thresh) begin
        threshold_sel <= wr_pins;
      end
      if (sel_rise) begin
        rise_en <= wr_pins;
      end
      if (sel_fall) begin
        fall_en <= wr_pins;
      end
      if (sel_mask) begin
        evt_mask <= wr_pins;
      end
      if (sel_ctrl) begin
        master_en <= avs_writedata_in[`PCI_BIT_MASTER_EN];
      end
    end
  end

  // Flags, event log and outputs
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags         <= NUM_PINS'(`PCI_RST_FLAGS);
      evt_status    <= NUM_PINS'(`PCI_RST_EVT_STATUS);
      irq_out       <= 1'b0;
      wake_out      <= 1'b0;
      pin_level_out <= '0;
    end else begin
      flags         <= next_flags;
      evt_status    <= next_evt_status;
      irq_out       <= next_irq;
      wake_out      <= next_wake;
      pin_level_out <= pin_sync;
    end
  end

  // Checks

  AST_THRESH_SELECT: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    ##2 pin_meta == $past(pin_chosen))
    else $error("Synchroniser did not take the selected threshold input");

  AST_UPPER_ZERO: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (!avs_waitrequest_out && avs_read_in && (sel_thresh || sel_rise || sel_fall || sel_flags))
      |-> avs_readdata_out[7:6] == 2'b00)
    else $error("Unimplemented upper bits read as one");

  AST_IRQ_CAUSE: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    irq_out |-> $past(master_en) && ($past(flags) != '0 || $past(edge_hit) != '0))
    else $error("Interrupt raised without master enable and a flag");

  AST_IRQ_RAISE: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (master_en && (flags & evt_mask) != '0 && !(wr_low && (sel_flags || sel_ctrl || sel_mask)))
      |=> irq_out)
    else $error("Interrupt missing while enabled flag stands");

  AST_NO_IRQ_DISABLED: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (!master_en && edge_hit != '0) |=> (flags != '0) && !irq_out)
    else $error("Disabled master enable blocked flags or raised interrupt");

  AST_RISE_SETS: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (pin_sync[0] && !pin_prev[0] && rise_en[0]) |=> flags[0])
    else $error("Enabled rising edge did not set its flag");

  AST_FALL_SETS: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (!pin_sync[0] && pin_prev[0] && fall_en[0]) |=> flags[0])
    else $error("Enabled falling edge did not set its flag");

  AST_NO_SPURIOUS: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (!$past(flags[0]) && flags[0]) |->
      ($past(rise_pulse[0] && rise_en[0]) || $past(fall_pulse[0] && fall_en[0])
       || $past(wr_low && sel_flags && wr_pins[0])))
    else $error("Flag set without an enabled edge or a write");

  AST_STICKY: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (flags[0] && !(wr_low && sel_flags)) |=> flags[0])
    else $error("Flag dropped without a software write");

  AST_SUMMARY: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (!avs_waitrequest_out && avs_read_in && sel_ctrl)
      |-> avs_readdata_out[`PCI_BIT_SUMMARY] == $past(|flags))
    else $error("Summary flag differs from OR of pin flags");

  AST_WRITE_CLEAR: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (wr_low && sel_flags && !wr_pins[0] && !edge_hit[0]) |=> !flags[0])
    else $error("Writing zero did not clear the flag");

  AST_SET_WINS: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (wr_low && sel_flags && edge_hit[0]) |=> flags[0])
    else $error("Edge lost during flag write");

  AST_WAKE: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (sleep_in && master_en && edge_hit != '0) |=> wake_out)
    else $error("Enabled edge in sleep did not wake");

  AST_WAKE_FLAG: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    wake_out |-> flags != '0 || $past(wr_low && sel_flags))
    else $error("Wake pulse without its flag set");

  AST_EDGE_ONE_CYCLE: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    rise_pulse[0] |=> !rise_pulse[0])
    else $error("Edge pulse lasted more than one cycle");

  AST_BUS_ONE_WAIT: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    $rose(bus_req) && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("Bus answer not after exactly one wait cycle");

  // Further checks, some over the whole vector so that pins above bit 0 are guarded as well

  AST_THRESH_MUX: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    pin_chosen == ((threshold_sel & pin_schmitt_in) | (~threshold_sel & pin_ttl_in)))
    else $error("Chosen pin view does not follow the threshold select");

  AST_LEVEL_FOLLOWS: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    pin_level_out == $past(pin_sync))
    else $error("Pin level output lags the synchronised view");

  AST_UPPER_WIDE: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (!avs_waitrequest_out && avs_read_in && (sel_thresh || sel_rise || sel_fall || sel_flags))
      |-> avs_readdata_out[31:NUM_PINS] == '0)
    else $error("Unimplemented upper bits not zero");

  AST_IRQ_NEEDS_FLAG: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    irq_out |-> $past(next_flags) != '0)
    else $error("Interrupt raised with no pin flag");

  AST_IRQ_MASTER_OFF: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !$past(master_en) |-> !irq_out)
    else $error("Interrupt raised with master enable clear");

  AST_RISE_MASKED: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (rise_pulse[0] && !rise_en[0]) |-> !edge_hit[0])
    else $error("Rising edge counted with its enable clear");

  AST_FALL_MASKED: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (fall_pulse[0] && !fall_en[0]) |-> !edge_hit[0])
    else $error("Falling edge counted with its enable clear");

  AST_BOTH_EDGES: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (rise_en[0] && fall_en[0] && (pin_sync[0] != pin_prev[0])) |-> edge_hit[0])
    else $error("Edge missed with both enables set");

  AST_EDGE_FLAGS_ALL: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    edge_hit != '0 |=> (flags & $past(edge_hit)) == $past(edge_hit))
    else $error("Enabled edge did not set every matching flag");

  AST_STICKY_ALL: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !(wr_low && sel_flags) |=> (flags & $past(flags)) == $past(flags))
    else $error("A pin flag dropped without a write");

  AST_WRITE_VALUE: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (wr_low && sel_flags) |=> flags == ($past(wr_pins) | $past(edge_hit)))
    else $error("Flag write did not leave written value plus fresh edges");

  AST_WAKE_CAUSE: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    wake_out |-> $past(sleep_in && master_en))
    else $error("Wake pulse while awake or with master enable clear");

  AST_NO_WAKE_OFF: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !master_en |=> !wake_out)
    else $error("Wake pulse with master enable clear");

  AST_FALL_ONE_CYCLE: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    fall_pulse[0] |=> !fall_pulse[0])
    else $error("Falling edge pulse lasted more than one cycle");

  AST_PULSE_EXCLUSIVE: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (rise_pulse & fall_pulse) == '0)
    else $error("Rising and falling pulse on one pin together");

  AST_IDLE_WAITS: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !bus_req |=> avs_waitrequest_out)
    else $error("Waitrequest low without a request");

  AST_STATUS_CLEAR: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (rd_done && sel_status) |=> evt_status == $past(edge_hit))
    else $error("Event status not cleared by its read");

  AST_CTRL_READBACK: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (!avs_waitrequest_out && avs_read_in && sel_ctrl)
      |-> avs_readdata_out[`PCI_BIT_MASTER_EN] == $past(master_en))
    else $error("Master enable read back wrong");

endmodule : pin_change_interrupt

// [pkg/pin_change_interrupt_pkg.sv]
// Purpose: Types shared by the pin-change interrupt block
// Assumes: Nothing beyond the register header
// Notes:   Holds the bus phase enumeration only
package pin_change_interrupt_pkg;

  typedef enum logic [0:0] {
    BUS_WAIT = 1'b0,
    BUS_ACK  = 1'b1
  } bus_phase_t;

endpackage : pin_change_interrupt_pkg

// [pkg/pin_change_interrupt_regs.svh]
// Purpose: Register map, field positions and reset values of the pin-change interrupt block
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one register per aligned word
// Notes:   Definitions only
`ifndef PIN_CHANGE_INTERRUPT_REGS_SVH
`define PIN_CHANGE_INTERRUPT_REGS_SVH

`define PCI_ADDR_W          5
`define PCI_OFS_THRESHOLD   5'h00
`define PCI_OFS_CORE_CTRL   5'h04
`define PCI_OFS_RISE_EN     5'h08
`define PCI_OFS_FALL_EN     5'h0C
`define PCI_OFS_FLAGS       5'h10
`define PCI_OFS_EVT_STATUS  5'h14
`define PCI_OFS_EVT_MASK    5'h18
`define PCI_OFS_PIN_LEVEL   5'h1C

`define PCI_BIT_MASTER_EN   3
`define PCI_BIT_SUMMARY     0

`define PCI_RST_THRESHOLD   8'h00
`define PCI_RST_RISE_EN     8'h00
`define PCI_RST_FALL_EN     8'h00
`define PCI_RST_FLAGS       8'h00
`define PCI_RST_EVT_STATUS  8'h00
`define PCI_RST_EVT_MASK    8'hFF
`define PCI_RST_MASTER_EN   1'b0
`define PCI_READ_UNMAPPED   32'h0000_0000

`endif

// [verification/pin_signal_model.sv]
// Purpose: Far side of the pin inputs: both threshold views of six external signals
// Assumes: Bench asks for levels; the signals move only just after a rising clock edge
// Notes:   Each requested level lasts whole cycles, so no sub-cycle pulse is produced
`timescale 1ns/10ps
module pin_signal_model #(
  parameter int NUM_PINS = 6
) (
  input  wire logic                clk_in,
  input  wire logic [NUM_PINS-1:0] schmitt_level_in,
  input  wire logic [NUM_PINS-1:0] ttl_level_in,
  output logic      [NUM_PINS-1:0] pin_schmitt_out,
  output logic      [NUM_PINS-1:0] pin_ttl_out
);
  // The two views may disagree, as a slow edge crosses one threshold first
  always_ff @(posedge clk_in) begin
    pin_schmitt_out <= schmitt_level_in;
    pin_ttl_out     <= ttl_level_in;
  end
endmodule : pin_signal_model

// [verification/tb_top.sv]
// Purpose: Self-checking bench of the pin-change interrupt block
// Assumes: One wait cycle per bus access; a flag settles within six cycles of a pin change
// Notes:   Every scenario is its own task and judges its own results
`timescale 1ns/10ps
`include "pin_change_interrupt_regs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic        clk_sys_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        sleep_in = 1'b0;
  logic [4:0]  avs_address_in = 5'h00;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0000_0000;
  logic [3:0]  avs_byteenable_in = 4'h0;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic        irq_out;
  logic        wake_out;
  logic [5:0]  pin_level_out;
  logic [5:0]  schmitt_level = 6'h00;
  logic [5:0]  ttl_level = 6'h00;
  logic [5:0]  pin_schmitt;
  logic [5:0]  pin_ttl;
  int          wake_count = 0;
  int          fails = 0;
  int          comparisons = 0;

  always #2.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (wake_out === 1'b1) wake_count <= wake_count + 1;

  pin_signal_model u_pins (.clk_in(clk_sys_in), .schmitt_level_in(schmitt_level),
    .ttl_level_in(ttl_level), .pin_schmitt_out(pin_schmitt), .pin_ttl_out(pin_ttl));

  pin_change_interrupt dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .pin_schmitt_in(pin_schmitt), .pin_ttl_in(pin_ttl), .sleep_in(sleep_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out), .wake_out(wake_out),
    .pin_level_out(pin_level_out));

  task automatic bus_access(input logic [4:0] a, input logic w, input logic [31:0] d,
                            input logic [3:0] b, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    avs_address_in    <= a;
    avs_write_in      <= w;
    avs_read_in       <= !w;
    avs_writedata_in  <= d;
    avs_byteenable_in <= b;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
    if (n >= 50) begin
      fails++;
      finish_test();
    end
  endtask : bus_access

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_access(a, 1'b1, d, 4'h1, q);
  endtask : wr

  task automatic check_reg(input string nm, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus_access(a, 1'b0, 32'h0000_0000, 4'h1, q);
    `CHK(nm, e, q)
  endtask : check_reg

  // Flags settle three edges after the pin view moves; six leaves margin for irq too
  task automatic set_pins(input logic [5:0] s, input logic [5:0] t);
    @(posedge clk_sys_in);
    schmitt_level <= s;
    ttl_level     <= t;
    repeat (6) @(posedge clk_sys_in);
  endtask : set_pins

  task automatic test_reset;
    check_reg("threshold", `PCI_OFS_THRESHOLD, 32'h0000_0000);
    check_reg("control", `PCI_OFS_CORE_CTRL, 32'h0000_0000);
    check_reg("rise_en", `PCI_OFS_RISE_EN, 32'h0000_0000);
    check_reg("fall_en", `PCI_OFS_FALL_EN, 32'h0000_0000);
    check_reg("flags", `PCI_OFS_FLAGS, 32'h0000_0000);
    check_reg("status", `PCI_OFS_EVT_STATUS, 32'h0000_0000);
    check_reg("mask", `PCI_OFS_EVT_MASK, 32'h0000_003F);
    `CHK("irq", 1'b0, irq_out)
    $display("test reset done");
  endtask : test_reset

  task automatic test_widths;
    logic [4:0]  ofs [4];
    logic [31:0] q;
    ofs = '{`PCI_OFS_THRESHOLD, `PCI_OFS_RISE_EN, `PCI_OFS_FALL_EN, `PCI_OFS_FLAGS};
    for (int i = 0; i < 4; i++) begin
      wr(ofs[i], 32'h0000_00FF);
      check_reg("upper bits", ofs[i], 32'h0000_003F);
    end
    bus_access(`PCI_OFS_THRESHOLD, 1'b1, 32'h0000_0000, 4'h0, q);
    check_reg("no byte enable", `PCI_OFS_THRESHOLD, 32'h0000_003F);
    for (int i = 1; i < 4; i++) wr(ofs[i], 32'h0000_0000);
    check_reg("flags cleared", `PCI_OFS_FLAGS, 32'h0000_0000);
    $display("test widths done");
  endtask : test_widths

  task automatic test_edges;
    logic [31:0] seen;
    logic [31:0] now;
    wr(`PCI_OFS_RISE_EN, 32'h0000_0005);
    wr(`PCI_OFS_FALL_EN, 32'h0000_0006);
    set_pins(6'h07, 6'h00);
    `CHK("level", 6'h07, pin_level_out)
    check_reg("rise flags", `PCI_OFS_FLAGS, 32'h0000_0005);
    `CHK("irq off", 1'b0, irq_out)
    check_reg("summary", `PCI_OFS_CORE_CTRL, 32'h0000_0001);
    set_pins(6'h00, 6'h00);
    check_reg("both flags", `PCI_OFS_FLAGS, 32'h0000_0007);
    check_reg("status", `PCI_OFS_EVT_STATUS, 32'h0000_0007);
    check_reg("status read", `PCI_OFS_EVT_STATUS, 32'h0000_0000);
    // Only bits already seen are cleared, so a fresh edge survives
    bus_access(`PCI_OFS_FLAGS, 1'b0, 32'h0000_0000, 4'h1, seen);
    bus_access(`PCI_OFS_FLAGS, 1'b0, 32'h0000_0000, 4'h1, now);
    wr(`PCI_OFS_FLAGS, now & (seen ^ 32'h0000_00FF));
    check_reg("cleared", `PCI_OFS_FLAGS, 32'h0000_0000);
    $display("test edges done");
  endtask : test_edges

  task automatic test_irq;
    wr(`PCI_OFS_CORE_CTRL, 32'h0000_0008);
    `CHK("irq no flag", 1'b0, irq_out)
    set_pins(6'h01, 6'h00);
    `CHK("irq raised", 1'b1, irq_out)
    wr(`PCI_OFS_EVT_MASK, 32'h0000_003E);
    repeat (2) @(posedge clk_sys_in);
    `CHK("irq masked", 1'b0, irq_out)
    wr(`PCI_OFS_EVT_MASK, 32'h0000_003F);
    repeat (2) @(posedge clk_sys_in);
    `CHK("irq unmasked", 1'b1, irq_out)
    wr(`PCI_OFS_FLAGS, 32'h0000_0000);
    repeat (2) @(posedge clk_sys_in);
    `CHK("irq cleared", 1'b0, irq_out)
    $display("test irq done");
  endtask : test_irq

  task automatic test_ttl;
    wr(`PCI_OFS_THRESHOLD, 32'h0000_0000);
    set_pins(6'h00, 6'h01);
    `CHK("ttl level", 6'h01, pin_level_out)
    check_reg("pin level", `PCI_OFS_PIN_LEVEL, 32'h0000_0001);
    set_pins(6'h04, 6'h01);
    check_reg("ttl flags", `PCI_OFS_FLAGS, 32'h0000_0001);
    wr(`PCI_OFS_FLAGS, 32'h0000_0000);
    $display("test ttl done");
  endtask : test_ttl

  task automatic test_sleep;
    int w0;
    w0 = wake_count;
    sleep_in <= 1'b1;
    set_pins(6'h04, 6'h05);
    `CHK("wake", w0 + 1, wake_count)
    check_reg("sleep flag", `PCI_OFS_FLAGS, 32'h0000_0004);
    wr(`PCI_OFS_CORE_CTRL, 32'h0000_0000);
    wr(`PCI_OFS_FLAGS, 32'h0000_0000);
    set_pins(6'h04, 6'h01);
    `CHK("no wake", w0 + 1, wake_count)
    check_reg("flag no master", `PCI_OFS_FLAGS, 32'h0000_0004);
    sleep_in <= 1'b0;
    $display("test sleep done");
  endtask : test_sleep

  task automatic finish_test;
    $display("checks %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    #100000;
    fails++;
    finish_test();
  end

  initial begin
    repeat (5) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    test_reset();
    test_widths();
    wr(`PCI_OFS_THRESHOLD, 32'h0000_003F);
    test_edges();
    test_irq();
    test_ttl();
    test_sleep();
    finish_test();
  end
endmodule : tb_top
